// *** common/mac_client_pkg.sv ***
// Shared constants, types and lane helpers for the MAC client stream port
`default_nettype none
package mac_client_pkg;
	localparam int DATA_W_DEF = 64;
	localparam int LANES_MAX = 8;
	localparam int LEN_W = 16;
	localparam int MAX_LEN_W = 15;
	localparam logic [15:0] MIN_FRAME_LEN = 16'h0040;
	localparam logic [15:0] CTRL_FRAME_LEN = 16'h0040;
	localparam logic [15:0] LEN_RESET = 16'h0000;
	localparam logic [1:0] BUF_COUNT_RESET = 2'h0;
	localparam logic [1:0] BUF_FULL = 2'h2;

	typedef enum logic [2:0]
	{
		TX_IDLE = 3'b001,
		TX_FRAME = 3'b010,
		TX_ABORT = 3'b100
	} tx_state_t;

	// Even parity of each byte lane
	function automatic logic [7:0] lane_parity(input logic [63:0] d);
		logic [7:0] p;
		for (int i = 0; i < LANES_MAX; i++)
		begin
			p[i] = ^d[8*i +: 8];
		end
		return p;
	endfunction

	// Number of valid lanes counted upward from lane 0
	function automatic logic [3:0] lane_count(input logic [7:0] k);
		logic [3:0] n;
		logic stop;
		n = 4'h0;
		stop = 1'b0;
		for (int i = 0; i < LANES_MAX; i++)
		begin
			if (k[i] && !stop)
				n = n + 4'h1;
			else
				stop = 1'b1;
		end
		return n;
	endfunction

	// Contiguous keep pattern of n lanes from lane 0
	function automatic logic [7:0] keep_mask(input logic [3:0] n);
		logic [7:0] m;
		for (int i = 0; i < LANES_MAX; i++)
		begin
			m[i] = 4'(i) < n;
		end
		return m;
	endfunction
endpackage
`default_nettype wire

// *** common/stream_buf_if.sv ***
// Fill and drain handshake between the transmit path and its buffer
`default_nettype none
interface stream_buf_if #(parameter int W = 8);
	logic fillValid;
	logic fillReady;
	logic [W-1:0] fillWord;
	logic drainValid;
	logic drainReady;
	logic [W-1:0] drainWord;
	modport user (output fillValid, output fillWord, input fillReady,
		input drainValid, input drainWord, output drainReady);
	modport store (input fillValid, input fillWord, output fillReady,
		output drainValid, output drainWord, input drainReady);
endinterface
`default_nettype wire

// *** logic/two_entry_buffer.sv ***
// Two-entry buffer with registered head word
`default_nettype none
module two_entry_buffer #(
	parameter int W = 8
) (
	input wire logic clk, // Core clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic ce, // Clock enable
	stream_buf_if.store bf // Fill and drain sides
);
	if (W < 1)
	begin : badWidth
		$error("two_entry_buffer: W must be at least 1");
	end

	logic [1:0] count;
	logic [1:0] next_count;
	logic [W-1:0] slot0;
	logic [W-1:0] slot1;
	logic [W-1:0] next_slot0;
	logic [W-1:0] next_slot1;
	logic push;
	logic pop;

	assign bf.fillReady = ce && (count != mac_client_pkg::BUF_FULL);
	assign bf.drainValid = count != mac_client_pkg::BUF_COUNT_RESET;
	assign bf.drainWord = slot0;
	assign push = bf.fillValid && bf.fillReady;
	assign pop = bf.drainValid && bf.drainReady && ce;

	always_comb
	begin
		next_count = count;
		next_slot0 = slot0;
		next_slot1 = slot1;
		if (pop && push)
		begin
			if (count == 2'h1)
				next_slot0 = bf.fillWord;
			else
			begin
				next_slot0 = slot1;
				next_slot1 = bf.fillWord;
			end
		end
		else if (pop)
		begin
			next_slot0 = slot1;
			next_count = count - 2'h1;
		end
		else if (push)
		begin
			if (count == 2'h0)
				next_slot0 = bf.fillWord;
			else
				next_slot1 = bf.fillWord;
			next_count = count + 2'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			count <= mac_client_pkg::BUF_COUNT_RESET;
			slot0 <= '0;
			slot1 <= '0;
		end
		else if (ce)
		begin
			count <= next_count;
			slot0 <= next_slot0;
			slot1 <= next_slot1;
		end
	end

	full_stalls_fill_a: assert property (@(posedge clk) disable iff (sys_rst)
		count == mac_client_pkg::BUF_FULL && !pop |=> count == mac_client_pkg::BUF_FULL
			&& slot1 == $past(slot1))
		else $error("buffer changed while full and not drained");
	word_reaches_head_a: assert property (@(posedge clk) disable iff (sys_rst)
		(count == 2'h0 && push) |=> (bf.drainValid && bf.drainWord == $past(bf.fillWord)))
		else $error("pushed word did not appear at the head");
endmodule
`default_nettype wire

// *** logic/mac_client_stream_port.sv ***
// Client stream port of the Ethernet MAC: transmit intake and receive delivery
// Behaviour
// - Transmit bus 64 or 32 bits; lane n is bits 8n+7:8n, keep n marks it.
// - After a final transfer, inputs are ignored until valid is next raised.
// - Valid may stay high across packets; only last marks boundaries.
// - Device may drop ready at any time to throttle the client.
// - Valid dropping mid-frame without last is an implicit underrun abort.
// - Any abort marks the outgoing frame with error codes.
// - Receive bus 64 or 32 bits, same lanes; keep n marks lane n.
// - Device outputs eight receive parity bits, one per lane.
// - Receive keep all ones except last; last keep contiguous from lane 0.
// - Receive last marks the final bytes, after the FCS is checked.
// - Receive user stays low on the last transfer of a good frame.
// - Receive user high for FCS, runt, oversize, bad control length or code errors.
// - Transmit port and datapath run on the transmit clock.
// - Receive port runs on the receive core clock; here it shares clk with the transmit port.
// - Resets are active high, held until the clock is stable, synchronised inside; here sys_rst goes straight to the flops as a synchronous reset.
`default_nettype none
module mac_client_stream_port #(
	parameter int DATA_W = mac_client_pkg::DATA_W_DEF
) (
	input wire logic clk, // Core clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire logic [DATA_W-1:0] txData, // Client transmit data
	input wire logic [DATA_W/8-1:0] txKeep, // Client lane valid
	input wire logic txValid, // Client word valid
	output logic txReady, // Word accepted
	input wire logic txLast, // Packet end
	input wire logic txUser, // Bad packet flag
	input wire logic [7:0] txParity, // Client lane parity
	output logic txParityErr, // Parity mismatch pulse
	output logic lineTxValid, // Word toward MAC datapath
	input wire logic lineTxReady, // MAC datapath takes word
	output logic [DATA_W-1:0] lineTxData, // Outgoing data
	output logic [DATA_W/8-1:0] lineTxKeep, // Outgoing lane valid
	output logic lineTxLast, // Outgoing packet end
	output logic lineTxErrCode, // Insert error codes in this frame
	input wire logic rxLineValid, // Decoded receive word
	input wire logic [DATA_W-1:0] rxLineData, // Decoded receive data
	input wire logic [DATA_W/8-1:0] rxLineKeep, // Decoded lane valid
	input wire logic rxLineLast, // FCS checked, frame end
	input wire logic rxLineFcsBad, // FCS mismatch at frame end
	input wire logic rxLineCodeErr, // Error code seen in word
	input wire logic rxLineCtrl, // Frame is a control frame
	input wire logic [14:0] rxMaxLen, // Largest legal frame
	output logic [DATA_W-1:0] rxData, // Client receive data
	output logic [DATA_W/8-1:0] rxKeep, // Client lane valid
	output logic rxValid, // Client word valid
	output logic rxLast, // Client frame end
	output logic rxUser, // Bad frame flag
	output logic [7:0] rxParity // Client lane parity
);
	localparam int KW = DATA_W / 8;
	localparam int BW = DATA_W + KW + 2;

	if (DATA_W != 32 && DATA_W != 64)
	begin : badWidth
		$error("mac_client_stream_port: DATA_W must be 32 or 64");
	end

	stream_buf_if #(.W(BW)) bf ();

	two_entry_buffer #(.W(BW)) txBuffer (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.bf(bf)
	);

	mac_client_pkg::tx_state_t txState;
	mac_client_pkg::tx_state_t next_txState;
	logic abortPush;
	logic acc;
	logic next_txParityErr;
	logic [7:0] txCalcParity;

	// Transfer only on valid and ready together
	assign txReady = bf.fillReady && (txState != mac_client_pkg::TX_ABORT);
	assign acc = txValid && txReady;
	assign txCalcParity = mac_client_pkg::lane_parity(64'(txData));

	always_comb
	begin
		next_txState = txState;
		abortPush = 1'b0;
		unique case (txState)
			mac_client_pkg::TX_IDLE:
			begin
				if (acc && !txLast)
					next_txState = mac_client_pkg::TX_FRAME;
			end
			mac_client_pkg::TX_FRAME:
			begin
				if (!txValid)
				begin
					abortPush = 1'b1;
					next_txState = bf.fillReady ? mac_client_pkg::TX_IDLE
						: mac_client_pkg::TX_ABORT;
				end
				else if (acc && txLast)
					next_txState = mac_client_pkg::TX_IDLE;
			end
			mac_client_pkg::TX_ABORT:
			begin
				abortPush = 1'b1;
				if (bf.fillReady)
					next_txState = mac_client_pkg::TX_IDLE;
			end
		endcase
	end

	// Abort word: empty keep, last and error set so the frame is stomped
	always_comb
	begin
		bf.fillValid = abortPush || (txValid && txState != mac_client_pkg::TX_ABORT);
		if (abortPush)
			bf.fillWord = {1'b1, 1'b1, {KW{1'b0}}, {DATA_W{1'b0}}};
		else
			bf.fillWord = {txUser && txLast, txLast, txKeep, txData};
		next_txParityErr = acc && |((txCalcParity[KW-1:0] ^ txParity[KW-1:0]) & txKeep);
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			txState <= mac_client_pkg::TX_IDLE;
			txParityErr <= 1'b0;
		end
		else if (ce)
		begin
			txState <= next_txState;
			txParityErr <= next_txParityErr;
		end
	end

	// Toward the MAC datapath, fed from the buffer head register
	assign bf.drainReady = lineTxReady;
	assign lineTxValid = bf.drainValid;
	assign {lineTxErrCode, lineTxLast, lineTxKeep, lineTxData} = bf.drainWord;

	logic [15:0] rxLen;
	logic [15:0] next_rxLen;
	logic [15:0] lenSum;
	logic codeSeen;
	logic next_codeSeen;
	logic frameBad;
	logic [KW-1:0] lineKeepEff;
	logic [KW-1:0] lastMask;
	logic [7:0] lineParity;
	logic [DATA_W-1:0] next_rxData;
	logic [KW-1:0] next_rxKeep;
	logic next_rxValid;
	logic next_rxLast;
	logic next_rxUser;
	logic [7:0] next_rxParity;

	assign lastMask = KW'(mac_client_pkg::keep_mask(
		mac_client_pkg::lane_count(8'(rxLineKeep))));
	assign lineParity = mac_client_pkg::lane_parity(64'(rxLineData));

	always_comb
	begin
		lineKeepEff = rxLineLast ? lastMask : {KW{1'b1}};
		lenSum = rxLen + 16'(mac_client_pkg::lane_count(8'(lineKeepEff)));
		frameBad = rxLineFcsBad || codeSeen || rxLineCodeErr
			|| lenSum < mac_client_pkg::MIN_FRAME_LEN
			|| lenSum > {1'b0, rxMaxLen}
			|| (rxLineCtrl && lenSum != mac_client_pkg::CTRL_FRAME_LEN);
		next_rxLen = rxLen;
		next_codeSeen = codeSeen;
		if (rxLineValid)
		begin
			next_rxLen = rxLineLast ? mac_client_pkg::LEN_RESET : lenSum;
			next_codeSeen = !rxLineLast && (codeSeen || rxLineCodeErr);
		end
		next_rxValid = rxLineValid;
		next_rxData = rxLineData;
		next_rxKeep = rxLineValid ? lineKeepEff : {KW{1'b0}};
		next_rxLast = rxLineValid && rxLineLast;
		next_rxUser = rxLineValid && rxLineLast && frameBad;
		next_rxParity = lineParity;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rxLen <= mac_client_pkg::LEN_RESET;
			codeSeen <= 1'b0;
			rxData <= '0;
			rxKeep <= '0;
			rxValid <= 1'b0;
			rxLast <= 1'b0;
			rxUser <= 1'b0;
			rxParity <= 8'h00;
		end
		else if (ce)
		begin
			rxLen <= next_rxLen;
			codeSeen <= next_codeSeen;
			rxData <= next_rxData;
			rxKeep <= next_rxKeep;
			rxValid <= next_rxValid;
			rxLast <= next_rxLast;
			rxUser <= next_rxUser;
			rxParity <= next_rxParity;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence txUnderrun;
		txState == mac_client_pkg::TX_FRAME && !txValid;
	endsequence
	sequence rxRuntEnd;
		ce && rxLineValid && rxLineLast && lenSum < mac_client_pkg::MIN_FRAME_LEN;
	endsequence
	sequence rxGoodEnd;
		ce && rxLineValid && rxLineLast && !rxLineFcsBad && !rxLineCodeErr && !codeSeen
			&& !rxLineCtrl && lenSum >= mac_client_pkg::MIN_FRAME_LEN
			&& lenSum <= {1'b0, rxMaxLen};
	endsequence

	abort_stalls_ready_a: assert property (
		txState == mac_client_pkg::TX_ABORT |-> !txReady && bf.fillValid && bf.fillWord[BW-1])
		else $error("abort word not offered while ready held low");
	underrun_marks_frame_a: assert property (
		txUnderrun |-> bf.fillValid && bf.fillWord[BW-1] && bf.fillWord[BW-2])
		else $error("underrun did not push an errored end word");
	explicit_abort_a: assert property (
		acc && txLast && txUser |-> bf.fillWord[BW-1])
		else $error("explicit abort not marked as errored");
	last_returns_idle_a: assert property (
		ce && acc && txLast && txState != mac_client_pkg::TX_ABORT
			|=> txState == mac_client_pkg::TX_IDLE)
		else $error("transmit path not idle after final transfer");
	rx_keep_full_a: assert property (
		rxValid && !rxLast |-> rxKeep == {KW{1'b1}})
		else $error("partial keep before frame end");
	rx_keep_contig_a: assert property (
		rxValid && rxLast |-> rxKeep == KW'(mac_client_pkg::keep_mask(
			mac_client_pkg::lane_count(8'(rxKeep)))))
		else $error("final keep not contiguous from lane 0");
	rx_last_follows_a: assert property (
		ce && rxLineValid && rxLineLast |=> rxValid && rxLast)
		else $error("frame end not delivered next cycle");
	rx_runt_flag_a: assert property (
		rxRuntEnd |=> rxLast && rxUser)
		else $error("short frame not flagged bad");
	rx_good_clean_a: assert property (
		rxGoodEnd |=> rxLast && !rxUser)
		else $error("good frame flagged bad");
	rx_parity_lanes_a: assert property (
		rxValid |-> rxParity == mac_client_pkg::lane_parity(64'(rxData)))
		else $error("receive parity wrong");
endmodule
`default_nettype wire

// *** tb/tx_client_model.sv ***
// Transmit client model feeding frames into the stream port
`default_nettype none
module tx_client_model (
	input wire logic clk, // Core clock
	input wire logic txReady, // Word taken
	output logic [63:0] txData, // Word data
	output logic [7:0] txKeep, // Lane valid
	output logic txValid, // Word valid
	output logic txLast, // Packet end
	output logic txUser, // Bad packet
	output logic [7:0] txParity // Lane parity
);
	timeunit 1ns;
	timeprecision 1ps;
	int timeouts = 0;
	initial
	begin
		{txData, txKeep, txValid, txLast, txUser, txParity} = '0;
	end
	// Present a word and hold it until taken
	task automatic put(input logic [63:0] d, input logic [7:0] k, input logic l,
		input logic u, input logic [7:0] flip);
		logic [7:0] p;
		int n;
		for (int i = 0; i < 8; i++)
			p[i] = ^d[8*i +: 8];
		txData <= d;
		txKeep <= k;
		txLast <= l;
		txUser <= u;
		txParity <= p ^ flip;
		txValid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (txReady !== 1'b1 && n < 200);
		if (txReady !== 1'b1)
			timeouts++;
	endtask
	// One idle cycle with the stale word scrambled
	task automatic gap();
		txValid <= 1'b0;
		txData <= ~txData;
		txKeep <= ~txKeep;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// *** tb/mac_client_stream_port_test.sv ***
// Self-checking bench for the MAC client stream port
`default_nettype none
module mac_client_stream_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic hold = 1'b0, ceDrop = 1'b0;
	logic [63:0] txData, lineTxData, rxData;
	logic [63:0] rxLineData = 64'h0;
	logic [7:0] txKeep, txParity, lineTxKeep, rxKeep, rxParity, m;
	logic [7:0] rxLineKeep = 8'h0;
	logic txValid, txReady, txLast, txUser, txParityErr, bad, rb;
	logic lineTxValid, lineTxLast, lineTxErrCode, rxValid, rxLast, rxUser;
	logic lineTxReady = 1'b1;
	logic rxLineValid = 1'b0, rxLineLast = 1'b0, rxLineFcsBad = 1'b0;
	logic rxLineCodeErr = 1'b0, rxLineCtrl = 1'b0, ceSeen = 1'b0;
	logic [14:0] rxMaxLen = 15'h0064;
	logic [73:0] expQ[$];
	logic [73:0] ex, txGot;
	logic [82:0] rxGot;
	logic [82:0] expRx = '0;
	logic inFrame = 1'b0, expPerr = 1'b0;
	int failCount = 0, comparisons = 0, rxLen = 0, n, w, k, ln;
	always #2 clk = ~clk;
	mac_client_stream_port #(.DATA_W(64)) i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.txData(txData), .txKeep(txKeep), .txValid(txValid), .txReady(txReady),
		.txLast(txLast), .txUser(txUser), .txParity(txParity), .txParityErr(txParityErr),
		.lineTxValid(lineTxValid), .lineTxReady(lineTxReady), .lineTxData(lineTxData),
		.lineTxKeep(lineTxKeep), .lineTxLast(lineTxLast), .lineTxErrCode(lineTxErrCode),
		.rxLineValid(rxLineValid), .rxLineData(rxLineData), .rxLineKeep(rxLineKeep),
		.rxLineLast(rxLineLast), .rxLineFcsBad(rxLineFcsBad), .rxLineCodeErr(rxLineCodeErr),
		.rxLineCtrl(rxLineCtrl), .rxMaxLen(rxMaxLen), .rxData(rxData), .rxKeep(rxKeep),
		.rxValid(rxValid), .rxLast(rxLast), .rxUser(rxUser), .rxParity(rxParity));
	tx_client_model i_client (.clk(clk), .txReady(txReady), .txData(txData),
		.txKeep(txKeep), .txValid(txValid), .txLast(txLast), .txUser(txUser),
		.txParity(txParity));
	assign rxGot = {rxData, rxKeep, rxParity, rxValid, rxLast, rxUser};
	assign txGot = {lineTxData, lineTxKeep, lineTxLast, lineTxErrCode};
	// Even parity of each lane
	function automatic logic [7:0] parityOf(input logic [63:0] d);
		logic [7:0] r;
		for (int i = 0; i < 8; i++)
			r[i] = ^d[8*i +: 8];
		return r;
	endfunction
	// Lanes valid without a hole, counted from lane 0
	function automatic int lanesOf(input logic [7:0] kp);
		int c;
		c = 0;
		while (c < 8 && kp[c])
			c++;
		return c;
	endfunction
	task automatic cmpWord(input logic [82:0] got, input logic [82:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failCount++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmpBit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			failCount++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic closeOut();
		$display("comparisons %0d mismatches %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Line sink with random stalls
	always @(posedge clk)
	begin
		lineTxReady <= hold ? 1'b0 : ($urandom % 4 != 0);
		ce <= !(ceDrop && $urandom % 8 == 0);
	end
	// Receive frame on the decoded line side
	task automatic rxFrame(input int words, input logic [7:0] lk, input logic fcs,
		input logic cerr, input logic ctl);
		for (int j = 0; j < words; j++)
		begin
			rxLineValid <= 1'b1;
			rxLineData <= {$urandom, $urandom};
			rxLineLast <= j == words - 1;
			rxLineKeep <= j == words - 1 ? lk : 8'($urandom);
			rxLineFcsBad <= fcs;
			rxLineCodeErr <= cerr && j == 1;
			rxLineCtrl <= ctl;
			@(posedge clk);
		end
		rxLineValid <= 1'b0;
		rxLineData <= ~rxLineData;
		@(posedge clk);
	endtask
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			expRx = '0;
			expPerr = 1'b0;
			inFrame = 1'b0;
			rxLen = 0;
			ceSeen = 1'b0;
		end
		else
		begin
			cmpBit(txParityErr, expPerr);
			cmpBit(rxValid, expRx[2]);
			if (expRx[2])
				cmpWord(rxGot, expRx);
			if (lineTxValid === 1'b1 && lineTxReady && ce)
			begin
				ex = expQ.size() > 0 ? expQ.pop_front() : '1;
				cmpWord(83'(txGot), 83'(ex));
			end
			bad = 1'b0;
			if (txValid && txReady === 1'b1)
			begin
				bad = |(txKeep & (parityOf(txData) ^ txParity));
				expQ.push_back({txData, txKeep, txLast, txUser & txLast});
				inFrame = !txLast;
			end
			else if (!txValid && inFrame && ce)
			begin
				expQ.push_back({64'h0, 8'h0, 1'b1, 1'b1});
				inFrame = 1'b0;
			end
			// A frozen cycle leaves every registered output as it was
			if (ce)
			begin
				expPerr = bad;
				expRx = '0;
			end
			if (ce && rxLineValid)
			begin
				ln = lanesOf(rxLineKeep);
				m = rxLineLast ? 8'hff >> (8 - ln) : 8'hff;
				rxLen += rxLineLast ? ln : 8;
				ceSeen |= rxLineCodeErr;
				rb = rxLineFcsBad || ceSeen || rxLen < 64 || rxLen > rxMaxLen;
				rb = rb || (rxLineCtrl && rxLen != 64);
				expRx = {rxLineData, m, parityOf(rxLineData), 1'b1, rxLineLast, rxLineLast & rb};
				if (rxLineLast)
				begin
					rxLen = 0;
					ceSeen = 1'b0;
				end
			end
		end
	end
	initial
	begin
		#(20000 * 4);
		failCount++;
		closeOut();
	end
	initial
	begin
		void'($urandom(87947));
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		hold <= 1'b1;
		@(posedge clk);
		#1 cmpBit(lineTxValid, 1'b0);
		cmpBit(txReady, 1'b1);
		@(posedge clk);
		// Stalled sink fills the buffer, bad parity on one word
		i_client.put(64'h1122334455667788, 8'hff, 1'b0, 1'b0, 8'h00);
		i_client.put(64'h99aabbccddeeff00, 8'hff, 1'b0, 1'b0, 8'h01);
		#1 cmpBit(txReady, 1'b0);
		@(posedge clk);
		hold <= 1'b0;
		i_client.put(64'h0102030405060708, 8'h07, 1'b1, 1'b0, 8'h00);
		ceDrop <= 1'b1;
		for (int f = 0; f < 40; f++)
		begin
			k = f % 4;
			w = 1 + $urandom % 5;
			for (int j = 0; j < w; j++)
				i_client.put({$urandom, $urandom}, 8'hff >> ($urandom % 8),
					j == w - 1 && k != 2, k == 1 && j == w - 1, 8'h00);
			if (k >= 2)
				i_client.gap();
		end
		ceDrop <= 1'b0;
		repeat (2) @(posedge clk);
		n = 0;
		while (expQ.size() > 0 && n < 300)
		begin
			@(posedge clk);
			n++;
		end
		cmpBit(expQ.size() == 0, 1'b1);
		cmpBit(i_client.timeouts == 0, 1'b1);
		rxFrame(8, 8'hff, 1'b0, 1'b0, 1'b0);
		rxFrame(8, 8'h7f, 1'b0, 1'b0, 1'b0);
		rxFrame(13, 8'hff, 1'b0, 1'b0, 1'b0);
		rxFrame(13, 8'h0f, 1'b0, 1'b0, 1'b0);
		rxFrame(8, 8'hff, 1'b0, 1'b0, 1'b1);
		rxFrame(9, 8'h0f, 1'b0, 1'b0, 1'b1);
		rxFrame(9, 8'hb7, 1'b0, 1'b0, 1'b0);
		rxFrame(10, 8'hff, 1'b1, 1'b0, 1'b0);
		rxFrame(10, 8'hff, 1'b0, 1'b1, 1'b0);
		for (int f = 0; f < 20; f++)
			rxFrame(7 + $urandom % 7, 8'($urandom), $urandom % 4 == 0, 1'b0, 1'b0);
		repeat (2) @(posedge clk);
		closeOut();
	end
endmodule
`default_nettype wire
